/* rtl/tuc_pkg.sv */
// shared constants and state types for the timer up-counter channel
package tuc_pkg;

    localparam int COUNT_W = 16;
    localparam int PRE_W = 5;

    // source clock select encodings
    localparam logic [1:0] SRC_EXT_PIN = 2'h0;
    localparam logic [1:0] SRC_DIV2 = 2'h1;
    localparam logic [1:0] SRC_DIV8 = 2'h2;
    localparam logic [1:0] SRC_DIV32 = 2'h3;

    // capture timing select encodings
    localparam logic [1:0] CAP_OFF = 2'h0;
    localparam logic [1:0] CAP_PIN_EDGES = 2'h1;
    localparam logic [1:0] CAP_ON_MATCH = 2'h2;
    localparam logic [1:0] CAP_RESERVED = 2'h3;

    // prescaler tap terminal counts: divide by 2, 8 and 32
    localparam logic [PRE_W-1:0] TAP2_MASK = 5'h01;
    localparam logic [PRE_W-1:0] TAP8_MASK = 5'h07;
    localparam logic [PRE_W-1:0] TAP32_MASK = 5'h1F;

    // reset values and counting constants
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [COUNT_W-1:0] COMPARE_RST = 16'h0000;
    localparam logic [COUNT_W-1:0] CAPTURE_RST = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
    localparam logic [PRE_W-1:0] PRE_RST = 5'h00;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic [PRE_W-1:0] PRE_ONE = 5'h01;

    typedef struct packed {
        logic [PRE_W-1:0] div;
        logic tick_div2;
        logic tick_div8;
        logic tick_div32;
    } tuc_pre_s;

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic [COUNT_W-1:0] cmp_a;
        logic [COUNT_W-1:0] cmp_p;
        logic [COUNT_W-1:0] buf_a;
        logic [COUNT_W-1:0] buf_p;
        logic [COUNT_W-1:0] cap_a;
        logic [COUNT_W-1:0] cap_b;
        logic ext_prev;
        logic match_a;
        logic match_p;
        logic ovf;
        logic irq;
        logic cirq_a;
        logic cirq_b;
    } tuc_core_s;

endpackage : tuc_pkg

/* rtl/tuc_tap_if.sv */
// carrier between the prescaler and the counter core
`timescale 1ns/1ps
interface tuc_tap_if;
    logic clear;
    logic tick_div2;
    logic tick_div8;
    logic tick_div32;

    modport prescaler (input clear, output tick_div2, output tick_div8, output tick_div32);
    modport core (output clear, input tick_div2, input tick_div8, input tick_div32);
endinterface : tuc_tap_if

/* rtl/tuc_prescaler.sv */
// prescaler producing one-cycle ticks at divide-by-2, 8 and 32
`timescale 1ns/1ps
module tuc_prescaler
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // taps toward the core
    tuc_tap_if.prescaler taps
);
    import tuc_pkg::*;

    tuc_pre_s st_q;
    tuc_pre_s st_d;

    ////////////////////////////////////////////////////////////////////////
    // divider held at zero while the counter is stopped, so the first
    // tick after a start always arrives at a fixed distance
    always_comb
    begin
        st_d = st_q;
        if (taps.clear)
        begin
            st_d = '0;
        end
        else
        begin
            st_d.div = st_q.div + PRE_ONE;
            st_d.tick_div2 = ((st_q.div & TAP2_MASK) == TAP2_MASK);
            st_d.tick_div8 = ((st_q.div & TAP8_MASK) == TAP8_MASK);
            st_d.tick_div32 = ((st_q.div & TAP32_MASK) == TAP32_MASK);
        end
    end

    // state register
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ticks leave straight from flip-flops
    assign taps.tick_div2 = st_q.tick_div2;
    assign taps.tick_div8 = st_q.tick_div8;
    assign taps.tick_div32 = st_q.tick_div32;

endmodule : tuc_prescaler

/* rtl/tuc_top.sv */
// timer channel core: 16-bit up-counter with compare, buffering and capture
`timescale 1ns/1ps
module tuc_top
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // mode and run control
    input wire logic count_run,
    input wire logic [1:0] source_clock_select,
    input wire logic clear_on_match_enable,
    input wire logic double_buffer_enable,
    input wire logic [1:0] capture_timing_select,
    // compare register writes
    input wire logic compare_a_write,
    input wire logic compare_period_write,
    input wire logic [tuc_pkg::COUNT_W-1:0] compare_wdata,
    // software capture bit write
    input wire logic soft_capture_write,
    input wire logic soft_capture_trigger,
    // external count pin
    input wire logic ext_count_input,
    // counter and register views
    output logic [tuc_pkg::COUNT_W-1:0] count_value,
    output logic [tuc_pkg::COUNT_W-1:0] compare_value_a,
    output logic [tuc_pkg::COUNT_W-1:0] compare_value_period,
    output logic [tuc_pkg::COUNT_W-1:0] capture_value_a,
    output logic [tuc_pkg::COUNT_W-1:0] capture_value_b,
    // event pulses
    output logic match_a_event,
    output logic match_period_event,
    output logic overflow_event,
    output logic timer_event_irq,
    output logic capture_irq_a,
    output logic capture_irq_b
);
    import tuc_pkg::*;

    tuc_core_s st_q;
    tuc_core_s st_d;
    tuc_tap_if taps ();

    logic count_tick;
    logic pin_rise;
    logic pin_fall;
    logic [COUNT_W-1:0] count_next;
    logic hit_a;
    logic hit_p;
    logic wrap;
    logic period_clear;
    logic cap_a_fire;
    logic cap_b_fire;
    logic immediate;

    ////////////////////////////////////////////////////////////////////////
    // prescaler taps, parked while stopped
    assign taps.clear = !count_run;

    tuc_prescaler u_prescaler
    (
        .clock (clock),
        .rstn (rstn),
        .taps (taps)
    );

    ////////////////////////////////////////////////////////////////////////
    // tap selection shared by the counter; kept as a function so the
    // encoding lives in one place
    function automatic logic pick_tick(input logic [1:0] sel, input logic pin, input logic t2,
                                       input logic t8, input logic t32);
        logic r;
        r = 1'b0;
        unique case (sel)
            SRC_EXT_PIN: r = pin;
            SRC_DIV2: r = t2;
            SRC_DIV8: r = t8;
            SRC_DIV32: r = t32;
        endcase
        return r;
    endfunction : pick_tick

    ////////////////////////////////////////////////////////////////////////
    // count source and pin edges; the pin is taken as synchronous, so a
    // single previous-value flop is enough for edge detection
    always_comb
    begin
        pin_rise = ext_count_input && !st_q.ext_prev;
        pin_fall = !ext_count_input && st_q.ext_prev;
        count_tick = count_run && pick_tick(source_clock_select, pin_rise, taps.tick_div2,
                                            taps.tick_div8, taps.tick_div32);
    end

    // next counter value and the conditions that go with it
    always_comb
    begin
        period_clear = clear_on_match_enable && (st_q.count == st_q.cmp_p);
        wrap = !period_clear && (st_q.count == COUNT_MAX);
        if (period_clear)
        begin
            count_next = COUNT_RST;
        end
        else
        begin
            count_next = st_q.count + COUNT_ONE;
        end
        hit_a = count_tick && (count_next == st_q.cmp_a);
        hit_p = count_tick && (count_next == st_q.cmp_p);
    end

    // capture timing: pin edges, or compare hits, steer the two latches
    always_comb
    begin
        cap_a_fire = 1'b0;
        cap_b_fire = 1'b0;
        unique case (capture_timing_select)
            CAP_OFF:
            begin
                cap_a_fire = 1'b0;
            end
            CAP_PIN_EDGES:
            begin
                cap_a_fire = pin_rise;
                cap_b_fire = pin_fall;
            end
            CAP_ON_MATCH:
            begin
                cap_a_fire = hit_p;
                cap_b_fire = hit_a;
            end
            CAP_RESERVED:
            begin
                cap_b_fire = 1'b0;
            end
        endcase
        if (soft_capture_write && !soft_capture_trigger)
        begin
            cap_a_fire = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state update; buffering is bypassed whenever it is off or the
    // counter is stopped, so writes land in the active register at once
    always_comb
    begin
        immediate = !double_buffer_enable || !count_run;
        st_d = st_q;
        st_d.ext_prev = ext_count_input;
        if (!count_run)
        begin
            st_d.count = COUNT_RST;
        end
        else if (count_tick)
        begin
            st_d.count = count_next;
        end
        // period match moves buffered values in; a write in the same
        // cycle refills the buffer and reaches the active register next time
        if (hit_p && !immediate)
        begin
            st_d.cmp_a = st_q.buf_a;
            st_d.cmp_p = st_q.buf_p;
        end
        if (compare_a_write)
        begin
            st_d.buf_a = compare_wdata;
            if (immediate)
            begin
                st_d.cmp_a = compare_wdata;
            end
        end
        if (compare_period_write)
        begin
            st_d.buf_p = compare_wdata;
            if (immediate)
            begin
                st_d.cmp_p = compare_wdata;
            end
        end
        // captures take the value the counter shows this cycle
        if (cap_a_fire)
        begin
            st_d.cap_a = st_q.count;
        end
        if (cap_b_fire)
        begin
            st_d.cap_b = st_q.count;
        end
        st_d.match_a = hit_a;
        st_d.match_p = hit_p;
        st_d.ovf = count_tick && wrap;
        st_d.irq = hit_a || hit_p || (count_tick && wrap);
        st_d.cirq_a = cap_a_fire;
        st_d.cirq_b = cap_b_fire;
    end

    // state register; compare and buffer registers all reset to zero, so they start equal
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q.count <= COUNT_RST;
            st_q.cmp_a <= COMPARE_RST;
            st_q.cmp_p <= COMPARE_RST;
            st_q.buf_a <= COMPARE_RST;
            st_q.buf_p <= COMPARE_RST;
            st_q.cap_a <= CAPTURE_RST;
            st_q.cap_b <= CAPTURE_RST;
            st_q.ext_prev <= 1'b0;
            st_q.match_a <= 1'b0;
            st_q.match_p <= 1'b0;
            st_q.ovf <= 1'b0;
            st_q.irq <= 1'b0;
            st_q.cirq_a <= 1'b0;
            st_q.cirq_b <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state flops
    assign count_value = st_q.count;
    assign compare_value_a = st_q.cmp_a;
    assign compare_value_period = st_q.cmp_p;
    assign capture_value_a = st_q.cap_a;
    assign capture_value_b = st_q.cap_b;
    assign match_a_event = st_q.match_a;
    assign match_period_event = st_q.match_p;
    assign overflow_event = st_q.ovf;
    assign timer_event_irq = st_q.irq;
    assign capture_irq_a = st_q.cirq_a;
    assign capture_irq_b = st_q.cirq_b;

endmodule : tuc_top

/* tb/tuc_chk.sv */
// assertion checker for the timer channel top
`timescale 1ns/1ps
module tuc_chk
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // controls
    input wire logic count_run,
    input wire logic clear_on_match_enable,
    input wire logic double_buffer_enable,
    input wire logic compare_a_write,
    input wire logic [tuc_pkg::COUNT_W-1:0] compare_wdata,
    input wire logic soft_capture_write,
    input wire logic soft_capture_trigger,
    // observed outputs
    input wire logic [tuc_pkg::COUNT_W-1:0] count_value,
    input wire logic [tuc_pkg::COUNT_W-1:0] compare_value_a,
    input wire logic [tuc_pkg::COUNT_W-1:0] compare_value_period,
    input wire logic [tuc_pkg::COUNT_W-1:0] capture_value_a,
    input wire logic match_a_event,
    input wire logic match_period_event,
    input wire logic overflow_event,
    input wire logic timer_event_irq
);
    import tuc_pkg::*;
    // one domain, so one clock and one reset for all
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);

    AST_STOP_CLR: assert property (!count_run |=> count_value == 16'h0000)
        else $error("count not cleared while stopped");
    AST_STEP: assert property ($changed(count_value) |->
        count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000)
        else $error("count moved by other than one");
    AST_OVF: assert property (overflow_event |-> count_value == 16'h0000 && $past(count_value) == 16'hFFFF)
        else $error("overflow without wrap");
    AST_IRQ: assert property (timer_event_irq == (match_a_event || match_period_event || overflow_event))
        else $error("timer event mismatch");
    AST_MATCH_A: assert property (match_a_event |-> count_value == $past(compare_value_a))
        else $error("match a at wrong count");
    // period hit seen with clear enabled: the following tick lands on zero
    AST_CLEAR: assert property ((count_run && clear_on_match_enable && count_value == compare_value_period)
        ##1 $changed(count_value) |-> count_value == 16'h0000)
        else $error("no clear after period hit");
    AST_SOFTCAP: assert property (soft_capture_write && !soft_capture_trigger
        |=> capture_value_a == $past(count_value))
        else $error("soft capture value wrong");
    AST_IMM_WR: assert property (compare_a_write && !count_run |=> compare_value_a == $past(compare_wdata))
        else $error("stopped write not immediate");
    AST_BUF_HOLD: assert property (compare_a_write && count_run && double_buffer_enable
        |=> match_period_event || $stable(compare_value_a))
        else $error("buffered write reached active early");
endmodule : tuc_chk

bind tuc_top tuc_chk tuc_chk_i (.clock, .rstn, .count_run, .clear_on_match_enable, .double_buffer_enable,
    .compare_a_write, .compare_wdata, .soft_capture_write, .soft_capture_trigger, .count_value,
    .compare_value_a, .compare_value_period, .capture_value_a, .match_a_event, .match_period_event,
    .overflow_event, .timer_event_irq);

/* tb/tuc_top_tb_top.sv */
// self-checking bench for the timer channel top
`timescale 1ns/1ps
module tuc_top_tb_top;
    import tuc_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic count_run = 1'b0;
    logic [1:0] source_clock_select = SRC_DIV2;
    logic clear_on_match_enable = 1'b1;
    logic double_buffer_enable = 1'b0;
    logic [1:0] capture_timing_select = CAP_OFF;
    logic compare_a_write = 1'b0;
    logic compare_period_write = 1'b0;
    logic [COUNT_W-1:0] compare_wdata = 16'h0000;
    logic soft_capture_write = 1'b0;
    logic soft_capture_trigger = 1'b1;
    logic ext_count_input = 1'b0;
    logic [COUNT_W-1:0] count_value, compare_value_a, compare_value_period, capture_value_a, capture_value_b;
    logic match_a_event, match_period_event, overflow_event, timer_event_irq, capture_irq_a, capture_irq_b;
    logic [COUNT_W-1:0] seen;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;

    always #5 clock = ~clock;

    tuc_top tuc_top_i (.clock, .rstn, .count_run, .source_clock_select, .clear_on_match_enable,
        .double_buffer_enable, .capture_timing_select, .compare_a_write, .compare_period_write, .compare_wdata,
        .soft_capture_write, .soft_capture_trigger, .ext_count_input, .count_value, .compare_value_a,
        .compare_value_period, .capture_value_a, .capture_value_b, .match_a_event, .match_period_event,
        .overflow_event, .timer_event_irq, .capture_irq_a, .capture_irq_b);

    ////////////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task ck(input logic [COUNT_W-1:0] got, input logic [COUNT_W-1:0] exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : ck

    // waits a bounded time for period hit (0), capture b (1) or a count change (2)
    task wt(input int s, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(negedge clock);
            if (s == 0 ? match_period_event === 1'b1 : s == 1 ? capture_irq_b === 1'b1 : count_value !== seen)
                return;
        end
        ck(16'h0001, 16'h0000, "awaited event missing");
    endtask : wt

    task wr(input logic per, input logic [COUNT_W-1:0] v);
        @(negedge clock);
        compare_wdata = v;
        compare_a_write = ~per;
        compare_period_write = per;
        @(negedge clock);
        compare_a_write = 1'b0;
        compare_period_write = 1'b0;
    endtask : wr

    task sc(input logic v);
        @(negedge clock);
        soft_capture_trigger = v;
        soft_capture_write = 1'b1;
        @(negedge clock);
        soft_capture_write = 1'b0;
    endtask : sc

    ////////////////////////////////////////////////////////////////////////////////
    task t_stopped;
        ck(compare_value_a, COMPARE_RST, "compare reset");
        double_buffer_enable = 1'b1;
        wr(1'b1, 16'h0009);
        wr(1'b0, 16'h0004);
        ck(compare_value_period, 16'h0009, "stopped period write");
        ck(compare_value_a, 16'h0004, "stopped a write");
    endtask : t_stopped

    // tick spacing of every prescaler tap
    task t_taps;
        logic [1:0] sel [3] = '{SRC_DIV2, SRC_DIV8, SRC_DIV32};
        int div [3] = '{2, 8, 32};
        int n;
        for (int k = 0; k < 3; k++)
        begin
            count_run = 1'b0;
            source_clock_select = sel[k];
            @(negedge clock);
            count_run = 1'b1;
            seen = count_value;
            wt(2, 80);
            seen = count_value;
            n = 0;
            while (count_value === seen && n < 80)
            begin
                @(negedge clock);
                n++;
            end
            ck(16'(n), 16'(div[k]), "tap spacing");
        end
        source_clock_select = SRC_DIV2;
    endtask : t_taps

    task t_clear_buf;
        wt(0, 100);
        ck(count_value, 16'h0009, "period hit count");
        ck({15'h0000, timer_event_irq}, 16'h0001, "timer event on hit");
        seen = count_value;
        wt(2, 8);
        ck(count_value, 16'h0000, "clear after hit");
        wr(1'b0, 16'h0003);
        ck(compare_value_a, 16'h0004, "buffered write held");
        wt(0, 100);
        ck(compare_value_a, 16'h0003, "transfer at period hit");
        clear_on_match_enable = 1'b0;
        ck(compare_value_period, 16'h0009, "period kept after transfer");
        seen = count_value;
        wt(2, 8);
        ck(count_value, 16'h000A, "free run past period");
    endtask : t_clear_buf

    task t_ext_cap;
        count_run = 1'b0;
        clear_on_match_enable = 1'b1;
        source_clock_select = SRC_EXT_PIN;
        @(negedge clock);
        ck(count_value, 16'h0000, "stop clears");
        count_run = 1'b1;
        repeat (3)
        begin
            ext_count_input = 1'b1;
            repeat (2) @(negedge clock);
            ext_count_input = 1'b0;
            repeat (2) @(negedge clock);
        end
        ck(count_value, 16'h0003, "pin rises counted");
        sc(1'b1);
        ck(capture_value_a, CAPTURE_RST, "capture on one");
        ck({15'h0000, capture_irq_a}, 16'h0000, "no capture event on one");
        sc(1'b0);
        ck(capture_value_a, 16'h0003, "soft capture");
        ck({15'h0000, capture_irq_a}, 16'h0001, "capture a event");
    endtask : t_ext_cap

    task t_cap_match;
        count_run = 1'b0;
        source_clock_select = SRC_DIV2;
        capture_timing_select = CAP_ON_MATCH;
        @(negedge clock);
        count_run = 1'b1;
        wt(1, 100);
        // the latch takes the count of the cycle in which the hit is decided
        ck(capture_value_b, 16'h0002, "capture b on a hit");
    endtask : t_cap_match

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
        t_stopped();
        t_taps();
        t_clear_buf();
        t_ext_cap();
        t_cap_match();
        finish_test();
    end

    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            finish_test();
        end
    end
endmodule : tuc_top_tb_top
